// ### logic/phy_cca_defs.svh
// register map, field positions, reset values and timing counts of the phy configuration block
// Function
// - measurement lasts two to the N times 32 us
// - mode 11: busy needs energy and carrier
// - mode 10: carrier-sense threshold alone decides
// - mode 01, reset value: energy threshold alone
// - mode 00: busy on energy or carrier
// - mean energy stored except in carrier mode
// - mean energy read-only, hardware written, resets zero
// - slow rates: 4,1,1 header byte-times, 64..8 us
// - 2 Mbps: 8,2,1 header byte-times, 4 us
// - rate taken from recognised delimiter pattern
// - bit 7 rejects 2 Mbps frames
// - bit 6 rejects 1 Mbps frames
// - bit 5 rejects 500 kbps frames
// - bit 4 rejects proprietary 250 kbps frames
// - bit 3 rejects standard 0xA7 frames
// - bit 2 rejects 125 kbps frames
// - bit 1 selects optimized preamble, resets one
// - 1M tolerant burst match, 2M exact pair
// - 125k two faulty nibbles, legacy exact
// - start bit runs one measurement, self-clears
// - busy when mean upper bits exceed threshold
`ifndef PHY_CCA_DEFS_SVH
`define PHY_CCA_DEFS_SVH

`define CCA_CTRL_TWO_ADDR 8'h2F
`define CCA_CTRL_ONE_ADDR 8'h30
`define ENERGY_MEAN_ADDR 8'h32
`define RATE_CFG_ADDR 8'h36

`define CS_THR_LSB 4
`define LEN_LSB 2
`define MODE_LSB 0
`define BUSY_BIT 7
`define START_BIT 6
`define ENERGY_THR_LSB 0
`define REJECT_LSB 2
`define PREAMBLE_SEL_BIT 1

`define CCA_CTRL_TWO_RST 8'h05
`define ENERGY_THR_RST 6'h0C
`define ENERGY_MEAN_RST 8'h00
`define RATE_CFG_RST 8'h03

`define CCA_MODE_OR 2'h0
`define CCA_MODE_ED_ONLY 2'h1
`define CCA_MODE_CS_ONLY 2'h2
`define CCA_MODE_AND 2'h3

`define STD_DELIM 8'hA7
`define DELIM_ONE_DEF 8'h21
`define DELIM_TWO_DEF 8'hF1
`define DELIM_THREE_DEF 8'h3B
`define DELIM_FOUR_DEF 8'hE5
`define DELIM_FIVE_DEF 8'h4D
`define DELIM_SIX_DEF 8'hA8
`define DELIM_SEVEN_DEF 8'hC8

`define CLK_PERIOD_NS 100
`define CCA_SLOT_US 32
`define CCA_SLOT_CYC ((`CCA_SLOT_US * 1000) / `CLK_PERIOD_NS)
`define BYTE_US_125K 64
`define BYTE_US_250K 32
`define BYTE_US_500K 16
`define BYTE_US_1M 8
`define BYTE_US_2M 4
`define US_TO_CYC(us) (((us) * 1000) / `CLK_PERIOD_NS)
`define PRE_BYTES_STD 4
`define DELIM_BYTES_STD 1
`define PRE_BYTES_2M 8
`define DELIM_BYTES_2M 2
`define LEN_BYTES 1

`endif

// ### logic/phy_cca_pkg.sv
// types and state records of the phy configuration block
package phy_cca_pkg;

    typedef enum logic [2:0] {RATE_NONE, RATE_125K, RATE_250K_STD, RATE_250K_PROP,
        RATE_500K, RATE_1M, RATE_2M} air_rate_t;

    typedef enum logic {MEAS_IDLE, MEAS_RUN} meas_state_t;

    typedef struct packed {
        meas_state_t state;
        logic [1:0] len;
        logic [1:0] mode;
        logic [3:0] carrier_sense_threshold;
        logic [5:0] edThr;
        logic [11:0] slotCnt;
        logic [3:0] slotsLeft;
        logic [10:0] sum;
        logic csHit;
        logic done;
        logic busy;
        logic [7:0] mean;
        logic meanWr;
    } meas_t;

    typedef struct packed {
        logic [7:0] ctrlTwo;
        logic [5:0] edThr;
        logic busy;
        logic startBit;
        logic [7:0] mean;
        logic [7:0] rateCfg;
        logic [7:0] rdData;
        logic [7:0] curByte;
        logic haveByte;
        air_rate_t rate;
        logic found;
        logic rejected;
        logic [9:0] byteCyc;
        logic [3:0] hdrBytes;
        logic hdrRun;
        logic [9:0] hdrCnt;
        logic payloadStart;
    } top_t;

endpackage

// ### logic/cca_measure.sv
// one channel assessment: timed energy averaging and carrier-sense watch
`timescale 1ns/1ps
`include "phy_cca_defs.svh"
module cca_measure import phy_cca_pkg::*; #(
    parameter int SLOT_CYCLES = `CCA_SLOT_CYC
) (
    input wire logic core_clk, // device clock
    input wire logic rst, // async reset, high
    input wire logic startReq, // begin a measurement when idle
    input wire logic [1:0] lenField, // assessment length N
    input wire logic [1:0] modeField, // assessment mode
    input wire logic [3:0] csThreshold, // carrier-sense threshold
    input wire logic [5:0] energyThreshold, // energy threshold
    input wire logic [7:0] rssiSample, // current signal strength
    input wire logic [3:0] csLevel, // carrier-sense correlation level
    output logic measActive, // measurement running
    output logic measDone, // one-cycle end pulse
    output logic [7:0] meanEnergy, // mean of the last measurement outside carrier mode
    output logic meanUpdate, // pulse: mean must be stored
    output logic busyResult // medium judged busy
);
    meas_t s, n;
    logic csNow;
    logic [10:0] sumNext;
    logic [7:0] meanV;
    logic [12:0] runCnt;

    // busy decision per mode
    function automatic logic judge(input logic [1:0] mode, input logic ed, input logic cs);
        case (mode)
            `CCA_MODE_AND: judge = ed & cs;
            `CCA_MODE_CS_ONLY: judge = cs;
            `CCA_MODE_ED_ONLY: judge = ed;
            default: judge = ed | cs;
        endcase
    endfunction

    // slot timer, averaging and verdict
    always_comb
    begin
        n = s;
        n.done = 1'b0;
        n.meanWr = 1'b0;
        csNow = s.csHit | (csLevel > s.carrier_sense_threshold);
        sumNext = s.sum + {3'h0, rssiSample};
        meanV = 8'(sumNext >> s.len);
        case (s.state)
            MEAS_IDLE:
                if (startReq)
                begin
                    n.state = MEAS_RUN;
                    n.len = lenField;
                    n.mode = modeField;
                    n.carrier_sense_threshold = csThreshold;
                    n.edThr = energyThreshold;
                    n.slotCnt = 12'h000;
                    n.slotsLeft = 4'(1 << lenField);
                    n.sum = 11'h000;
                    n.csHit = 1'b0;
                end
            MEAS_RUN:
            begin
                n.csHit = csNow;
                if (s.slotCnt == 12'(SLOT_CYCLES - 1))
                begin
                    n.slotCnt = 12'h000;
                    n.sum = sumNext;
                    n.slotsLeft = s.slotsLeft - 4'h1;
                    if (s.slotsLeft == 4'h1)
                    begin
                        n.state = MEAS_IDLE;
                        n.done = 1'b1;
                        n.busy = judge(s.mode, meanV[7:2] > s.edThr, csNow);
                        if (s.mode != `CCA_MODE_CS_ONLY)
                        begin
                            n.mean = meanV;
                            n.meanWr = 1'b1;
                        end
                    end
                end
                else
                    n.slotCnt = s.slotCnt + 12'h001;
            end
            default: n.state = MEAS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    assign measActive = (s.state == MEAS_RUN);
    assign measDone = s.done;
    assign meanEnergy = s.mean;
    assign meanUpdate = s.meanWr;
    assign busyResult = s.busy;

    // run length counter for checking
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            runCnt <= 13'h0000;
        else if (s.state == MEAS_RUN)
            runCnt <= runCnt + 13'h0001;
        else
            runCnt <= 13'h0000;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_meas_length: assert property (s.done |-> runCnt == 13'(SLOT_CYCLES << s.len))
        else $error("measurement length wrong");
    chk_and_mode: assert property ((s.done && s.mode == `CCA_MODE_AND) |->
        s.busy == (s.csHit && (s.mean[7:2] > s.edThr)))
        else $error("and-mode verdict wrong");
    chk_cs_mode: assert property ((s.done && s.mode == `CCA_MODE_CS_ONLY) |->
        (s.busy == s.csHit) && !s.meanWr)
        else $error("carrier mode verdict wrong");
    chk_ed_mode: assert property ((s.done && s.mode == `CCA_MODE_ED_ONLY) |->
        s.meanWr && (s.busy == (s.mean[7:2] > s.edThr)))
        else $error("energy mode verdict wrong");
    chk_or_mode: assert property ((s.done && s.mode == `CCA_MODE_OR) |->
        s.busy == (s.csHit || (s.mean[7:2] > s.edThr)))
        else $error("or-mode verdict wrong");
    chk_frozen_cfg: assert property ((s.state == MEAS_RUN && n.state == MEAS_RUN) |=>
        $stable(s.mode) && $stable(s.len) && $stable(s.carrier_sense_threshold))
        else $error("settings changed mid-run");
endmodule

// ### logic/delim_match.sv
// delimiter pattern comparison for every air rate
`timescale 1ns/1ps
`include "phy_cca_defs.svh"
module delim_match #(
    parameter logic [7:0] OCTET_ONE = `DELIM_ONE_DEF,
    parameter logic [7:0] OCTET_TWO = `DELIM_TWO_DEF,
    parameter logic [7:0] OCTET_THREE = `DELIM_THREE_DEF,
    parameter logic [7:0] OCTET_FOUR = `DELIM_FOUR_DEF,
    parameter logic [7:0] OCTET_FIVE = `DELIM_FIVE_DEF,
    parameter logic [7:0] OCTET_SIX = `DELIM_SIX_DEF,
    parameter logic [7:0] OCTET_SEVEN = `DELIM_SEVEN_DEF
) (
    input wire logic [15:0] word, // last two bytes, newest low
    input wire logic optimal, // optimized preamble selected
    output logic [5:0] hits // 2M,1M,500k,250k prop,250k std,125k
);
    // at most two separate two-bit error bursts
    function automatic logic burst_ok(input logic [15:0] x);
        int runs;
        int len;
        logic ok;
        runs = 0;
        len = 0;
        ok = 1'b1;
        for (int i = 0; i <= 16; i++)
        begin
            if (i < 16 && x[i])
                len++;
            else
            begin
                if (len != 0)
                begin
                    ok = ok & (len == 2);
                    runs++;
                end
                len = 0;
            end
        end
        burst_ok = ok & (runs <= 2);
    endfunction

    // count of differing nibbles
    function automatic logic [2:0] nib_faults(input logic [15:0] a, input logic [15:0] b);
        nib_faults = 3'h0;
        for (int k = 0; k < 4; k++)
            nib_faults = nib_faults + {2'h0, a[4*k +: 4] != b[4*k +: 4]};
    endfunction

    // pattern compare per preamble type
    always_comb
    begin
        hits[5] = optimal ? (word == {OCTET_ONE, OCTET_SIX}) : (word[7:0] == OCTET_ONE);
        hits[4] = optimal ? burst_ok(word ^ {OCTET_TWO, OCTET_SEVEN}) : (word[7:0] == OCTET_TWO);
        hits[3] = (word[7:0] == OCTET_THREE);
        hits[2] = (word[7:0] == OCTET_FOUR);
        hits[1] = (word[7:0] == `STD_DELIM);
        hits[0] = optimal ? (nib_faults(word, {OCTET_FIVE, OCTET_SIX}) <= 3'h2)
            : (word == {OCTET_FIVE, OCTET_SIX});
    end
endmodule

// ### logic/phy_cca_and_rate_config.sv
// phy configuration: assessment registers, rate detection and header timing
`timescale 1ns/1ps
`include "phy_cca_defs.svh"
module phy_cca_and_rate_config import phy_cca_pkg::*; #(
    parameter int SLOT_CYCLES = `CCA_SLOT_CYC
) (
    input wire logic core_clk, // device clock, 10 MHz
    input wire logic rst, // async reset, high
    input wire logic [7:0] regAddr, // register address
    input wire logic [7:0] regWrData, // register write data
    input wire logic regWrEn, // write strobe, one cycle
    input wire logic regRdEn, // read strobe, one cycle
    output logic [7:0] regRdData, // read data, next cycle
    input wire logic [7:0] rssiSample, // signal strength from receiver
    input wire logic [3:0] csLevel, // carrier-sense level from receiver
    input wire logic symValid, // new received byte
    input wire logic [7:0] symByte, // received byte
    output logic mediumBusy, // last assessment verdict
    output logic ccaActive, // assessment running
    output logic rateFound, // pulse: accepted delimiter
    output air_rate_t frameRate, // rate of last accepted frame
    output logic frameRejected, // pulse: delimiter of disabled rate
    output logic [9:0] byteCycles, // byte-time of current rate
    output logic [3:0] headerByteTimes, // header length in byte-times
    output logic payloadStart, // pulse: payload begins
    output logic optimalPreamble, // optimized preamble selected
    output logic powerSaveSelect // stored power-save bit
);
    top_t s, n;
    logic measDone;
    logic [7:0] meanEnergy;
    logic meanUpdate;
    logic busyResult;
    logic [5:0] hits;
    logic [5:0] rateOk;
    logic wrCtrlOne;
    logic startReq;

    // byte-time per rate in cycles
    function automatic logic [9:0] byte_cycles(input air_rate_t r);
        case (r)
            RATE_125K: byte_cycles = 10'(`US_TO_CYC(`BYTE_US_125K));
            RATE_250K_STD: byte_cycles = 10'(`US_TO_CYC(`BYTE_US_250K));
            RATE_250K_PROP: byte_cycles = 10'(`US_TO_CYC(`BYTE_US_250K));
            RATE_500K: byte_cycles = 10'(`US_TO_CYC(`BYTE_US_500K));
            RATE_1M: byte_cycles = 10'(`US_TO_CYC(`BYTE_US_1M));
            RATE_2M: byte_cycles = 10'(`US_TO_CYC(`BYTE_US_2M));
            default: byte_cycles = 10'h000;
        endcase
    endfunction

    // header byte-times before payload
    function automatic logic [3:0] hdr_bytes(input air_rate_t r);
        case (r)
            RATE_2M: hdr_bytes = 4'(`PRE_BYTES_2M + `DELIM_BYTES_2M + `LEN_BYTES);
            RATE_NONE: hdr_bytes = 4'h0;
            default: hdr_bytes = 4'(`PRE_BYTES_STD + `DELIM_BYTES_STD + `LEN_BYTES);
        endcase
    endfunction

    // fastest enabled matching rate
    function automatic air_rate_t pick_rate(input logic [5:0] ok);
        if (ok[5])
            pick_rate = RATE_2M;
        else if (ok[4])
            pick_rate = RATE_1M;
        else if (ok[3])
            pick_rate = RATE_500K;
        else if (ok[2])
            pick_rate = RATE_250K_PROP;
        else if (ok[1])
            pick_rate = RATE_250K_STD;
        else if (ok[0])
            pick_rate = RATE_125K;
        else
            pick_rate = RATE_NONE;
    endfunction

    // one assessment engine
    cca_measure #(
        .SLOT_CYCLES(SLOT_CYCLES)
    ) u_measure (
        .core_clk(core_clk),
        .rst(rst),
        .startReq(startReq),
        .lenField(s.ctrlTwo[`LEN_LSB +: 2]),
        .modeField(s.ctrlTwo[`MODE_LSB +: 2]),
        .csThreshold(s.ctrlTwo[`CS_THR_LSB +: 4]),
        .energyThreshold(s.edThr),
        .rssiSample(rssiSample),
        .csLevel(csLevel),
        .measActive(ccaActive),
        .measDone(measDone),
        .meanEnergy(meanEnergy),
        .meanUpdate(meanUpdate),
        .busyResult(busyResult)
    );

    // delimiter comparison on the newest word
    delim_match u_match (
        .word({s.curByte, symByte}),
        .optimal(s.rateCfg[`PREAMBLE_SEL_BIT]),
        .hits(hits)
    );

    // disabled rates masked out
    // per-rate reject masks
    assign rateOk = hits & ~s.rateCfg[`REJECT_LSB +: 6];
    assign wrCtrlOne = regWrEn && (regAddr == `CCA_CTRL_ONE_ADDR);
    // start held back at done cycle
    assign startReq = s.startBit && !measDone;

    // registers, rate detection and header timer
    always_comb
    begin
        n = s;
        n.found = 1'b0;
        n.rejected = 1'b0;
        n.payloadStart = 1'b0;
        // register writes
        if (regWrEn)
        begin
            if (regAddr == `CCA_CTRL_TWO_ADDR)
                n.ctrlTwo = regWrData;
            else if (regAddr == `CCA_CTRL_ONE_ADDR)
                n.edThr = regWrData[`ENERGY_THR_LSB +: 6];
            else if (regAddr == `RATE_CFG_ADDR)
                n.rateCfg = regWrData;
        end
        if (measDone)
            n.startBit = 1'b0;
        if (wrCtrlOne && regWrData[`START_BIT])
            n.startBit = 1'b1;
        if (measDone)
            n.busy = busyResult;
        if (meanUpdate)
            n.mean = meanEnergy;
        // register reads
        if (regRdEn)
        begin
            if (regAddr == `CCA_CTRL_TWO_ADDR)
                n.rdData = s.ctrlTwo;
            else if (regAddr == `CCA_CTRL_ONE_ADDR)
                n.rdData = {s.busy, s.startBit, s.edThr};
            else if (regAddr == `ENERGY_MEAN_ADDR)
                n.rdData = s.mean;
            else if (regAddr == `RATE_CFG_ADDR)
                n.rdData = s.rateCfg;
            else
                n.rdData = 8'h00;
        end
        // byte history and delimiter search
        if (symValid && !s.hdrRun)
        begin
            n.curByte = symByte;
            n.haveByte = 1'b1;
            if (|rateOk)
            begin
                n.found = 1'b1;
                n.rate = pick_rate(rateOk);
                n.byteCyc = byte_cycles(pick_rate(rateOk));
                n.hdrBytes = hdr_bytes(pick_rate(rateOk));
                n.hdrRun = 1'b1;
                n.hdrCnt = 10'h000;
                n.curByte = 8'h00;
                n.haveByte = 1'b0;
            end
            else if (|hits)
                n.rejected = 1'b1;
        end
        // length field byte-time, then payload
        if (s.hdrRun)
        begin
            if (s.hdrCnt == s.byteCyc - 10'h001)
            begin
                n.hdrRun = 1'b0;
                n.payloadStart = 1'b1;
            end
            else
                n.hdrCnt = s.hdrCnt + 10'h001;
        end
    end

    // state register with documented reset values
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.ctrlTwo <= `CCA_CTRL_TWO_RST;
            s.edThr <= `ENERGY_THR_RST;
            s.mean <= `ENERGY_MEAN_RST;
            s.rateCfg <= `RATE_CFG_RST;
            s.rate <= RATE_NONE;
        end
        else
            s <= n;
    end

    // outputs straight from state
    assign regRdData = s.rdData;
    assign mediumBusy = s.busy;
    assign rateFound = s.found;
    assign frameRate = s.rate;
    assign frameRejected = s.rejected;
    assign byteCycles = s.byteCyc;
    assign headerByteTimes = s.hdrBytes;
    assign payloadStart = s.payloadStart;
    assign optimalPreamble = s.rateCfg[`PREAMBLE_SEL_BIT];
    assign powerSaveSelect = s.rateCfg[0];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_start_clear: assert property ((measDone && !(wrCtrlOne && regWrData[`START_BIT]))
        |=> !s.startBit)
        else $error("start bit not cleared at end");
    chk_start_launch: assert property ((s.startBit && !ccaActive && !measDone)
        |=> ccaActive)
        else $error("start bit did not launch a run");
    chk_mean_hold: assert property (!meanUpdate |=> $stable(s.mean))
        else $error("mean changed without measurement");
    chk_mean_store: assert property (meanUpdate |=> s.mean == $past(meanEnergy))
        else $error("mean not stored");
    chk_busy_flag: assert property (measDone |=> s.busy == $past(busyResult))
        else $error("busy flag not updated");
    chk_reject_two_m: assert property ((symValid && !s.hdrRun && hits[5]
        && s.rateCfg[7]) |=> !(s.found && s.rate == RATE_2M))
        else $error("2M frame accepted while disabled");
    chk_reject_one_m: assert property ((symValid && !s.hdrRun && hits[4]
        && s.rateCfg[6]) |=> !(s.found && s.rate == RATE_1M))
        else $error("1M frame accepted while disabled");
    chk_reject_500k: assert property ((symValid && !s.hdrRun && hits[3]
        && s.rateCfg[5]) |=> !(s.found && s.rate == RATE_500K))
        else $error("500k frame accepted while disabled");
    chk_reject_prop: assert property ((symValid && !s.hdrRun && hits[2]
        && s.rateCfg[4]) |=> !(s.found && s.rate == RATE_250K_PROP))
        else $error("proprietary 250k accepted while disabled");
    chk_reject_std: assert property ((symValid && !s.hdrRun && hits[1]
        && s.rateCfg[3]) |=> !(s.found && s.rate == RATE_250K_STD))
        else $error("standard 250k accepted while disabled");
    chk_reject_all: assert property ((symValid && !s.hdrRun && (|hits) && !(|rateOk))
        |=> s.rejected && !s.found)
        else $error("disabled delimiter not rejected");
    chk_header_slow: assert property ((s.found && s.rate == RATE_1M) |->
        s.byteCyc == 10'd80 && s.hdrBytes == 4'h6)
        else $error("1M header timing wrong");
    chk_header_fast: assert property ((s.found && s.rate == RATE_2M) |->
        s.byteCyc == 10'd40 && s.hdrBytes == 4'hB)
        else $error("2M header timing wrong");
    chk_payload_time: assert property ((s.found && s.rate == RATE_2M) |->
        ##40 s.payloadStart)
        else $error("payload start late or early");

    cov_busy_medium: cover property (measDone && busyResult);
    cov_found_two_m: cover property (s.found && s.rate == RATE_2M);
    cov_rejected: cover property (s.rejected);
    cov_payload: cover property (s.payloadStart);
endmodule

// ### verification/radio_model.sv
// over-the-air peer: delimiter bytes and channel levels
`timescale 1ns/1ps
module radio_model (
    input wire logic core_clk, // device clock
    output logic symValid, // byte strobe
    output logic [7:0] symByte, // received byte
    output logic [7:0] rssiSample, // signal strength
    output logic [3:0] csLevel // carrier level
);
    // quiet air at start
    initial
    begin
        symValid = 1'b0;
        symByte = 8'h00;
        rssiSample = 8'h00;
        csLevel = 4'h0;
    end
    task automatic sendByte(input logic [7:0] b);
        @(negedge core_clk);
        symByte = b;
        symValid = 1'b1;
        @(negedge core_clk);
        symValid = 1'b0;
        symByte = ~b; // stale byte never lingers
    endtask
    // channel levels seen by the receiver
    task automatic setLevel(input logic [7:0] r, input logic [3:0] c);
        @(negedge core_clk);
        rssiSample = r;
        csLevel = c;
    endtask
endmodule

// ### verification/test_phy_cca_and_rate_config.sv
// self-checking bench of the phy configuration block
`timescale 1ns/1ps
`include "phy_cca_defs.svh"
module test_phy_cca_and_rate_config import phy_cca_pkg::*; ();
    localparam int SLOTS = 8;
    typedef struct packed {logic [7:0] cfg; logic [15:0] w; air_rate_t r;} rx_row_t;
    typedef struct packed {logic [7:0] c2, rssi; logic [3:0] cs; logic bsy;
        logic [7:0] mean;} cca_row_t;
    logic core_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, ok;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rssiSample, symByte;
    logic symValid, mediumBusy, ccaActive, rateFound, frameRejected;
    logic payloadStart, optimalPreamble, powerSaveSelect;
    logic [3:0] csLevel, headerByteTimes;
    logic [9:0] byteCycles, n;
    logic [16:0] last;
    air_rate_t frameRate;
    int n_fail = 0, n_tests = 0;
    // frame rows: rate config, received word, accepted rate
    rx_row_t rxRows [15] = '{'{8'h03, 16'h21A8, RATE_2M}, '{8'h03, 16'hF1C8, RATE_1M},
        '{8'h03, 16'hF1CB, RATE_1M}, '{8'h03, 16'h003B, RATE_500K},
        '{8'h03, 16'h00E5, RATE_250K_PROP}, '{8'h03, 16'h00A7, RATE_250K_STD},
        '{8'h03, 16'h4DA8, RATE_125K}, '{8'h03, 16'h4D11, RATE_125K},
        '{8'h87, 16'h21A8, RATE_NONE}, '{8'h43, 16'hF1C8, RATE_NONE},
        '{8'h23, 16'h003B, RATE_NONE}, '{8'h13, 16'h00E5, RATE_NONE},
        '{8'h0B, 16'h00A7, RATE_NONE}, '{8'h07, 16'h4DA8, RATE_NONE},
        '{8'h01, 16'h0021, RATE_2M}};
    // assessment rows: control two, levels, verdict, mean
    cca_row_t ccaRows [9] = '{'{8'h31, 8'h40, 4'h0, 1'b1, 8'h40},
        '{8'h3D, 8'h30, 4'h5, 1'b0, 8'h30}, '{8'h32, 8'h40, 4'h0, 1'b0, 8'h30},
        '{8'h36, 8'h10, 4'h5, 1'b1, 8'h30}, '{8'h33, 8'h40, 4'h0, 1'b0, 8'h40},
        '{8'h33, 8'h40, 4'h5, 1'b1, 8'h40}, '{8'h30, 8'h10, 4'h5, 1'b1, 8'h10},
        '{8'h30, 8'h10, 4'h0, 1'b0, 8'h10},
        '{8'h39, 8'h40, 4'h0, 1'b1, 8'h40}}; // 128 us length
    phy_cca_and_rate_config #(.SLOT_CYCLES(SLOTS)) dut (.core_clk(core_clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .rssiSample(rssiSample), .csLevel(csLevel),
        .symValid(symValid), .symByte(symByte), .mediumBusy(mediumBusy),
        .ccaActive(ccaActive), .rateFound(rateFound), .frameRate(frameRate),
        .frameRejected(frameRejected), .byteCycles(byteCycles),
        .headerByteTimes(headerByteTimes), .payloadStart(payloadStart),
        .optimalPreamble(optimalPreamble), .powerSaveSelect(powerSaveSelect));
    radio_model u_air (.core_clk(core_clk), .symValid(symValid), .symByte(symByte),
        .rssiSample(rssiSample), .csLevel(csLevel));
    always #50 core_clk = ~core_clk;
    // byte-time and header length of a rate
    function automatic logic [13:0] hdrOf(air_rate_t r);
        case (r)
            RATE_2M: return {10'h028, 4'hB};
            RATE_1M: return {10'h050, 4'h6};
            RATE_500K: return {10'h0A0, 4'h6};
            RATE_125K: return {10'h280, 4'h6};
            default: return {10'h140, 4'h6};
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        chk(regRdData, e);
    endtask
    // watchdog well past the longest run
    initial
    begin
        #3000000;
        n_fail++;
        final_report();
    end
    // main sequence
    initial
    begin
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        foreach (rxRows[i])
        begin
            wr(`RATE_CFG_ADDR, rxRows[i].cfg);
            u_air.sendByte(rxRows[i].w[15:8]);
            u_air.sendByte(rxRows[i].w[7:0]);
            // found or rejected pulse stands at this falling edge
            ok = rxRows[i].r != RATE_NONE;
            if (ok)
                last = {rxRows[i].r, hdrOf(rxRows[i].r)};
            chk({rateFound, frameRejected, frameRate, byteCycles, headerByteTimes},
                {ok, !ok, last});
            n = 10'h000;
            while (ok && payloadStart !== 1'b1 && n < 10'h3FF)
            begin
                @(negedge core_clk);
                n++;
            end
            if (ok)
                chk(n, last[13:4]);
        end
        foreach (ccaRows[i])
        begin
            wr(`CCA_CTRL_TWO_ADDR, ccaRows[i].c2);
            u_air.setLevel(ccaRows[i].rssi, ccaRows[i].cs);
            wr(`CCA_CTRL_ONE_ADDR, 8'h4C);
            // settings rewritten mid-run apply next run
            wr(`CCA_CTRL_TWO_ADDR, ~ccaRows[i].c2);
            n = 10'h001; // one run cycle passed during the write
            while (ccaActive === 1'b1 && n < 10'h3FF)
            begin
                @(negedge core_clk);
                n++;
            end
            @(negedge core_clk);
            chk({n, mediumBusy}, {10'(SLOTS << ccaRows[i].c2[3:2]), ccaRows[i].bsy});
            rdChk(`CCA_CTRL_ONE_ADDR, {ccaRows[i].bsy, 7'h0C});
            rdChk(`ENERGY_MEAN_ADDR, ccaRows[i].mean);
        end
        rst = 1'b1;
        @(negedge core_clk);
        rst = 1'b0;
        chk({optimalPreamble, powerSaveSelect}, 2'h3);
        rdChk(`CCA_CTRL_TWO_ADDR, 8'h05);
        rdChk(`RATE_CFG_ADDR, 8'h03);
        wr(`ENERGY_MEAN_ADDR, 8'hFF);
        rdChk(`ENERGY_MEAN_ADDR, 8'h00);
        rdChk(8'h40, 8'h00);
        final_report();
    end
endmodule
